// ===== core/bmsl_pkg.sv
// Constants for the boot mode serial loader: stream layout, divider,
// register offsets and field encodings.
// Assumes one 250 MHz clock and an APB master with 32-bit data.
package bmsl_pkg;

  // Stream and serial clock
  localparam int unsigned MODE_BITS = 256;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned SCLK_DIV  = 256;
  localparam logic [CNT_W-1:0] SCLK_HALF_M1 = 8'h7f;
  localparam logic [CNT_W-1:0] LAST_BIT     = 8'hff;
  localparam int unsigned KEEP_W    = 15;

  // Field positions inside the mode stream
  localparam int unsigned B_RSVD0   = 0;
  localparam int unsigned B_WB_LO   = 1;
  localparam int unsigned B_WB_HI   = 4;
  localparam int unsigned B_MUL_LO  = 5;
  localparam int unsigned B_MUL_HI  = 7;
  localparam int unsigned B_ENDIAN  = 8;
  localparam int unsigned B_WP_LO   = 9;
  localparam int unsigned B_WP_HI   = 10;
  localparam int unsigned B_TMR_DIS = 11;
  localparam int unsigned B_ONE12   = 12;
  localparam int unsigned B_DRV_LO  = 13;
  localparam int unsigned B_DRV_HI  = 14;

  // Field encodings
  localparam logic [3:0] WB_LAST_CODE  = 4'h8;
  localparam logic [2:0] MUL_RSVD      = 3'h7;
  localparam logic [3:0] MUL_BASE      = 4'h2;
  localparam logic [1:0] WP_RSVD       = 2'h1;
  localparam logic [3:0] MUL_RESET     = 4'h2;

  // APB register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MODE   = 8'h08;
  localparam logic [7:0] OFF_DECODE = 8'h0c;

  // CTRL bits
  localparam int unsigned C_RELOAD = 0;
  // STATUS bits
  localparam int unsigned S_DONE     = 0;
  localparam int unsigned S_LOADING  = 1;
  localparam int unsigned S_FAULT    = 2;
  localparam int unsigned S_WB_RSVD  = 3;
  localparam int unsigned S_MUL_RSVD = 4;
  localparam int unsigned S_WP_RSVD  = 5;
  localparam int unsigned S_CNT_LO   = 8;
  // DECODE bits
  localparam int unsigned D_WB_LO   = 0;
  localparam int unsigned D_MUL_LO  = 4;
  localparam int unsigned D_ENDIAN  = 8;
  localparam int unsigned D_WP_LO   = 9;
  localparam int unsigned D_TMR_DIS = 11;
  localparam int unsigned D_DRV_LO  = 12;

  typedef enum logic [1:0] {
    BMSL_IDLE,
    BMSL_LOAD,
    BMSL_DONE
  } bmsl_state_t;

endpackage

// ===== core/bmsl_clkdiv.sv
// Free-running divider for the boot serial clock.
// Assumes the core clock is the reference clock of the loader.
module bmsl_clkdiv (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Divided clock
  output logic      sclk,
  output logic      sclk_rise
);

  logic [bmsl_pkg::CNT_W-1:0] cnt;
  logic [bmsl_pkg::CNT_W-1:0] next_cnt;
  logic                       next_sclk;
  logic                       next_rise;

  // Divide by 256, half high and half low
  always_comb begin
    next_cnt  = cnt + 8'h01;
    next_sclk = next_cnt > bmsl_pkg::SCLK_HALF_M1;
    next_rise = cnt == bmsl_pkg::SCLK_HALF_M1;
  end

  // Never stops, so the clock keeps running after the load
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 8'h00;
      sclk      <= 1'b0;
      sclk_rise <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      sclk      <= next_sclk;
      sclk_rise <= next_rise;
    end
  end

  // Serial clock stays high for at least 8 cycles after each rise pulse
  property p_sclk_half;
    @(posedge clock) disable iff (!rst_n)
      sclk_rise |=> sclk [*8];
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock high phase too short");

  // No second rise pulse within 8 cycles of a rise pulse
  property p_sclk_period;
    @(posedge clock) disable iff (!rst_n)
      sclk_rise |=> !sclk_rise [*8];
  endproperty
  a_sclk_period: assert property (p_sclk_period)
    else $error("serial clock rise pulses too close");

endmodule

// ===== core/bmsl_loader.sv
// Boot mode serial loader: shifts in the 256-bit mode stream after
// supply good, decodes the fields and offers them over APB.
// Assumes inputs synchronous to clock and a serial source that
// changes data around the falling edge of the serial clock.
//
// Operation
// - Take exactly 256 mode bits after supply good
// - Serial clock is reference clock divided by 256
// - Clock keeps running; later data ignored
// - Bits 4:1 writeback pattern; 9-15 reserved
// - Bits 7:5 multiplier 2..8; 7 reserved
// - Bit 8: 0 little, 1 big endian
// - Bits 10:9 write protocol; 01 reserved
// - Bit 11 keeps timer off interrupt 5
// - Bits 14:13 output driver strength
// - Pipeline clock is reference times multiplier
module bmsl_loader (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Boot serial link
  input  wire logic        supply_good,
  input  wire logic        boot_serial_data_in,
  output logic             boot_serial_clock_out,
  // Interrupt routing
  input  wire logic        timer_irq,
  input  wire logic        ext_int5,
  output logic             int5_line,
  // Decoded modes
  output logic             mode_ready,
  output logic [3:0]       wb_pattern,
  output logic [3:0]       pll_multiplier,
  output logic             big_endian,
  output logic [1:0]       write_protocol,
  output logic [1:0]       drive_strength
);

  logic                                sclk_rise;
  bmsl_pkg::bmsl_state_t               state;
  bmsl_pkg::bmsl_state_t               next_state;
  logic [bmsl_pkg::CNT_W-1:0]          bit_cnt;
  logic [bmsl_pkg::CNT_W-1:0]          next_bit_cnt;
  logic [bmsl_pkg::KEEP_W-1:0]         mode;
  logic [bmsl_pkg::KEEP_W-1:0]         next_mode;
  logic                                fault;
  logic                                next_fault;
  logic                                reload;
  logic [3:0]                          next_wb;
  logic [3:0]                          next_mul;
  logic                                next_endian;
  logic [1:0]                          next_wp;
  logic [1:0]                          next_drv;
  logic                                next_ready;
  logic                                next_int5;
  logic                                setup;
  logic [31:0]                         next_prdata;
  logic                                next_slverr;

  // Serial clock divider
  bmsl_clkdiv u_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .sclk      (boot_serial_clock_out),
    .sclk_rise (sclk_rise)
  );

  // Write of CTRL reload bit restarts the load
  assign setup  = psel && !penable;
  assign reload = psel && penable && pwrite && pready &&
                  paddr == bmsl_pkg::OFF_CTRL &&
                  pwdata[bmsl_pkg::C_RELOAD];

  // Load sequencer and shift capture
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_mode    = mode;
    next_fault   = fault;
    case (state)
      bmsl_pkg::BMSL_IDLE: begin
        if (supply_good) begin
          next_state   = bmsl_pkg::BMSL_LOAD;
          next_bit_cnt = 8'h00;
          next_mode    = '0;
          next_fault   = 1'b0;
        end
      end
      bmsl_pkg::BMSL_LOAD: begin
        if (!supply_good) begin
          next_state = bmsl_pkg::BMSL_IDLE;
        end else if (sclk_rise) begin
          // Bit index equals count, so bit 0 is the first sample
          if (bit_cnt < 8'(bmsl_pkg::KEEP_W)) begin
            next_mode[4'(bit_cnt)] = boot_serial_data_in;
          end
          // Values the source must send, noted as a fault only
          if (bit_cnt == 8'(bmsl_pkg::B_RSVD0) ||
              bit_cnt >= 8'(bmsl_pkg::KEEP_W)) begin
            next_fault = fault | boot_serial_data_in;
          end else if (bit_cnt == 8'(bmsl_pkg::B_ONE12)) begin
            next_fault = fault | !boot_serial_data_in;
          end
          next_bit_cnt = bit_cnt + 8'h01;
          if (bit_cnt == bmsl_pkg::LAST_BIT) begin
            next_state = bmsl_pkg::BMSL_DONE;
          end
        end
      end
      bmsl_pkg::BMSL_DONE: begin
        // Serial data no longer sampled here
        if (!supply_good) begin
          next_state = bmsl_pkg::BMSL_IDLE;
        end
      end
      default: next_state = bmsl_pkg::BMSL_IDLE;
    endcase
    if (reload) begin
      next_state = bmsl_pkg::BMSL_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state   <= bmsl_pkg::BMSL_IDLE;
      bit_cnt <= 8'h00;
      mode    <= '0;
      fault   <= 1'b0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      mode    <= next_mode;
      fault   <= next_fault;
    end
  end

  // Field decode; outputs other than int5_line change only once the whole stream is in
  always_comb begin
    next_ready  = state == bmsl_pkg::BMSL_DONE;
    next_wb     = mode[bmsl_pkg::B_WB_HI:bmsl_pkg::B_WB_LO];
    next_mul    = {1'b0, mode[bmsl_pkg::B_MUL_HI:bmsl_pkg::B_MUL_LO]}
                  + bmsl_pkg::MUL_BASE;
    next_endian = mode[bmsl_pkg::B_ENDIAN];
    next_wp     = mode[bmsl_pkg::B_WP_HI:bmsl_pkg::B_WP_LO];
    next_drv    = mode[bmsl_pkg::B_DRV_HI:bmsl_pkg::B_DRV_LO];
    // Timer routing follows mode bit 11 as soon as it is sampled, during the load
    next_int5   = ext_int5 ||
                  (timer_irq && !mode[bmsl_pkg::B_TMR_DIS]);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ready     <= 1'b0;
      wb_pattern     <= 4'h0;
      pll_multiplier <= bmsl_pkg::MUL_RESET;
      big_endian     <= 1'b0;
      write_protocol <= 2'h0;
      drive_strength <= 2'h0;
      int5_line      <= 1'b0;
    end else begin
      mode_ready <= next_ready;
      if (next_ready) begin
        wb_pattern     <= next_wb;
        pll_multiplier <= next_mul;
        big_endian     <= next_endian;
        write_protocol <= next_wp;
        drive_strength <= next_drv;
      end
      int5_line <= next_int5;
    end
  end

  // APB read mux, decoded in setup so data stands in access phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      bmsl_pkg::OFF_CTRL: next_prdata = 32'h0000_0000;
      bmsl_pkg::OFF_STATUS: begin
        next_prdata[bmsl_pkg::S_DONE]    = state == bmsl_pkg::BMSL_DONE;
        next_prdata[bmsl_pkg::S_LOADING] = state == bmsl_pkg::BMSL_LOAD;
        next_prdata[bmsl_pkg::S_FAULT]   = fault;
        next_prdata[bmsl_pkg::S_WB_RSVD] =
          mode[bmsl_pkg::B_WB_HI:bmsl_pkg::B_WB_LO] >
          bmsl_pkg::WB_LAST_CODE;
        next_prdata[bmsl_pkg::S_MUL_RSVD] =
          mode[bmsl_pkg::B_MUL_HI:bmsl_pkg::B_MUL_LO] ==
          bmsl_pkg::MUL_RSVD;
        next_prdata[bmsl_pkg::S_WP_RSVD] =
          mode[bmsl_pkg::B_WP_HI:bmsl_pkg::B_WP_LO] ==
          bmsl_pkg::WP_RSVD;
        next_prdata[bmsl_pkg::S_CNT_LO +: bmsl_pkg::CNT_W] = bit_cnt;
      end
      bmsl_pkg::OFF_MODE: next_prdata[bmsl_pkg::KEEP_W-1:0] = mode;
      bmsl_pkg::OFF_DECODE: begin
        next_prdata[bmsl_pkg::D_WB_LO +: 4]  = wb_pattern;
        next_prdata[bmsl_pkg::D_MUL_LO +: 4] = pll_multiplier;
        next_prdata[bmsl_pkg::D_ENDIAN]      = big_endian;
        next_prdata[bmsl_pkg::D_WP_LO +: 2]  = write_protocol;
        next_prdata[bmsl_pkg::D_TMR_DIS]     = mode[bmsl_pkg::B_TMR_DIS];
        next_prdata[bmsl_pkg::D_DRV_LO +: 2] = drive_strength;
      end
      default: next_slverr = 1'b1;
    endcase
  end

  // One-cycle access phase: pready rises with the setup-to-access step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && next_slverr;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Load starts on supply good and takes 256 samples
  sequence s_load_start;
    state == bmsl_pkg::BMSL_IDLE && supply_good && !reload;
  endsequence

  property p_load_start;
    @(posedge clock) disable iff (!rst_n)
      s_load_start |=> state == bmsl_pkg::BMSL_LOAD && bit_cnt == 8'h00;
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("load did not start on supply good");

  property p_load_end;
    @(posedge clock) disable iff (!rst_n)
      state == bmsl_pkg::BMSL_LOAD && sclk_rise &&
      bit_cnt == bmsl_pkg::LAST_BIT && supply_good && !reload
      |=> state == bmsl_pkg::BMSL_DONE ##1 mode_ready;
  endproperty
  a_load_end: assert property (p_load_end)
    else $error("load did not end after bit 255");

  property p_count_step;
    @(posedge clock) disable iff (!rst_n)
      state == bmsl_pkg::BMSL_LOAD && !sclk_rise
      |=> bit_cnt == $past(bit_cnt);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("bit count moved without a serial clock rise");

  property p_done_frozen;
    @(posedge clock) disable iff (!rst_n)
      state == bmsl_pkg::BMSL_DONE |=> $stable(mode);
  endproperty
  a_done_frozen: assert property (p_done_frozen)
    else $error("mode changed after load completed");

  property p_mult;
    @(posedge clock) disable iff (!rst_n)
      mode_ready |-> pll_multiplier ==
        {1'b0, mode[bmsl_pkg::B_MUL_HI:bmsl_pkg::B_MUL_LO]} +
        bmsl_pkg::MUL_BASE;
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier not code plus two");

  property p_endian;
    @(posedge clock) disable iff (!rst_n)
      mode_ready |-> big_endian == mode[bmsl_pkg::B_ENDIAN];
  endproperty
  a_endian: assert property (p_endian)
    else $error("endianness does not follow bit 8");

  property p_fields;
    @(posedge clock) disable iff (!rst_n)
      mode_ready |->
        write_protocol == mode[bmsl_pkg::B_WP_HI:bmsl_pkg::B_WP_LO] &&
        drive_strength == mode[bmsl_pkg::B_DRV_HI:bmsl_pkg::B_DRV_LO] &&
        wb_pattern == mode[bmsl_pkg::B_WB_HI:bmsl_pkg::B_WB_LO];
  endproperty
  a_fields: assert property (p_fields)
    else $error("decoded fields do not match stream");

  property p_timer_mask;
    @(posedge clock) disable iff (!rst_n)
      mode[bmsl_pkg::B_TMR_DIS] && !ext_int5 && $stable(mode)
      |=> !int5_line;
  endproperty
  a_timer_mask: assert property (p_timer_mask)
    else $error("timer reached interrupt 5 while disabled");

  // Each sampling rise in the load moves the count on by one
  property p_count_next;
    @(posedge clock) disable iff (!rst_n)
      state == bmsl_pkg::BMSL_LOAD && sclk_rise && supply_good && !reload
      |=> bit_cnt == $past(bit_cnt) + 8'h01;
  endproperty
  a_count_next: assert property (p_count_next)
    else $error("bit count did not advance on a serial clock rise");

  // Sampled data lands at the bit given by the count
  property p_capture;
    @(posedge clock) disable iff (!rst_n)
      state == bmsl_pkg::BMSL_LOAD && sclk_rise && supply_good &&
      !reload && bit_cnt < 8'(bmsl_pkg::KEEP_W)
      |=> mode[$past(bit_cnt[3:0])] == $past(boot_serial_data_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("serial bit stored at the wrong position");

  // Clock keeps running when complete, yet the load restarts only after a reload or a supply drop
  property p_done_hold;
    @(posedge clock) disable iff (!rst_n)
      state == bmsl_pkg::BMSL_DONE && supply_good && !reload
      |=> state == bmsl_pkg::BMSL_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("complete state left without abort or reload");

endmodule

// ===== verif/bmsl_src.sv
// Serial mode source model: presents a 256-bit stream, bit 0 first.
// Assumes the loader samples data at each rise of its serial clock.
module bmsl_src (
  // Clock and link
  input  wire logic         clock,
  input  wire logic         supply_good,
  input  wire logic         sclk,
  input  wire logic [255:0] stream,
  // Data to loader
  output logic              sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned idx  = 256;
  logic        seen = 1'b0;
  logic        junk = 1'b0;

  // Restart at supply good with bit 0 on the line
  always @(posedge supply_good) begin
    idx = 0;
    seen = 1'b0;
  end
  // A fall before the first sampling rise must not skip bit 0
  always @(posedge sclk) seen = 1'b1;
  always @(negedge sclk) if (seen && idx < 256) idx = idx + 1;
  // Released line toggles so stale data never looks valid
  always @(posedge clock) junk <= ~junk;
  assign sdata = (idx < 256) ? stream[idx] : junk;
endmodule

// ===== verif/bmsl_loader_tb.sv
// Bench for the boot mode loader: one full load, APB reads, reload.
// Assumes the serial source model and a single 250 MHz clock.
module bmsl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        err;
    logic [31:0] mask;
    logic [31:0] data;
  } bmsl_exp_t;
  logic         clock = 1'b0;
  logic         rst_n, psel, penable, pwrite, supply_good, sdata;
  logic         timer_irq, ext_int5, sclk, int5_line, mode_ready;
  logic         pready, pslverr, big_endian;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, r, seed = 32'h0000_293d;
  logic [3:0]   wb_pattern, pll_multiplier, wb, mult;
  logic [1:0]   write_protocol, drive_strength, wp, drv;
  logic [2:0]   mul;
  logic         en;
  logic [255:0] stream = '0;
  bmsl_exp_t    exp_q[$];
  bmsl_exp_t    e;
  int           n_errors = 0;
  int           n_tests = 0;
  time          t1;

  bmsl_loader uut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_good(supply_good), .boot_serial_data_in(sdata),
    .boot_serial_clock_out(sclk), .timer_irq(timer_irq),
    .ext_int5(ext_int5), .int5_line(int5_line), .mode_ready(mode_ready),
    .wb_pattern(wb_pattern), .pll_multiplier(pll_multiplier),
    .big_endian(big_endian), .write_protocol(write_protocol),
    .drive_strength(drive_strength));
  bmsl_src src (.clock(clock), .supply_good(supply_good), .sclk(sclk),
    .stream(stream), .sdata(sdata));

  // 4 ns period
  always #2 clock = ~clock;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d compares=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; the expected answer goes to the queue
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] x, input logic err);
    int i;
    exp_q.push_back({err, m, x});
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Returns one edge after the serial clock has risen
  task automatic wait_rise();
    int   i;
    logic p;
    p = sclk;
    for (i = 0; i < 600; i++) begin
      @(posedge clock);
      if (sclk === 1'b1 && p === 1'b0) return;
      p = sclk;
    end
    n_errors++;
    end_sim();
  endtask

  // Answer monitor: oldest note against each completed transfer
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, e.err});
      check(prdata & e.mask, e.data);
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, supply_good, timer_irq, ext_int5} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    r = xs();
    {drv, wp, en, mul, wb} = {r[12:11], r[9:8], r[15], r[6:4], r[3:0]};
    stream[14:0] = {drv, 1'b1, 1'b1, wp, en, mul, wb, 1'b0};
    mult = (mul == 3'h7) ? 4'h9 : {1'b0, mul} + 4'h2;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check({28'h0, pll_multiplier}, 32'h2);
    timer_irq <= 1'b1;
    repeat (2) @(posedge clock);
    check({31'h0, int5_line}, 32'h1);
    apb(1'b0, 8'h04, 32'h0, 32'h3, 32'h0, 1'b0);
    apb(1'b1, 8'h40, 32'h1, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h40, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    wait_rise();
    t1 = $time;
    wait_rise();
    check(32'($time - t1), 32'h0000_0400);
    supply_good <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, 32'h3, 32'h2, 1'b0);
    check({31'h0, mode_ready}, 32'h0);
    for (int i = 0; i < 70000 && mode_ready !== 1'b1; i++)
      @(posedge clock);
    if (mode_ready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    check({28'h0, wb_pattern}, {28'h0, wb});
    check({28'h0, pll_multiplier}, {28'h0, mult});
    check({31'h0, big_endian}, {31'h0, en});
    check({30'h0, write_protocol}, {30'h0, wp});
    check({30'h0, drive_strength}, {30'h0, drv});
    apb(1'b0, 8'h04, 32'h0, 32'h3f,
        {26'h0, wp == 2'h1, mul == 3'h7, wb > 4'h8, 3'h1}, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h3fff,
        {18'h0, drv, 1'b1, wp, en, mult, wb}, 1'b0);
    // Later serial data and stray writes must leave the mode alone
    wait_rise();
    wait_rise();
    apb(1'b1, 8'h08, 32'h0, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h7fff, {17'h0, stream[14:0]}, 1'b0);
    timer_irq <= 1'b1;
    repeat (2) @(posedge clock);
    check({31'h0, int5_line}, 32'h0);
    ext_int5 <= 1'b1;
    repeat (2) @(posedge clock);
    check({31'h0, int5_line}, 32'h1);
    // Reload while supply good, then abort by dropping it
    apb(1'b1, 8'h00, 32'h1, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h3, 32'h2, 1'b0);
    check({31'h0, mode_ready}, 32'h0);
    // Stale source data in the restart must raise the fault flag
    repeat (14) wait_rise();
    apb(1'b0, 8'h04, 32'h0, 32'h7, 32'h6, 1'b0);
    supply_good <= 1'b0;
    apb(1'b0, 8'h04, 32'h0, 32'h3, 32'h0, 1'b0);
    repeat (4) @(posedge clock);
    if (exp_q.size() != 0) n_errors++;
    end_sim();
  end
endmodule
